//--- inc/drc_regs.svh
// register offsets, field positions, reset values and timing counts of the refresh block
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

`define DRC_REFRESH_CONTROL_OFS      8'h36
`define DRC_REFRESH_CONTROL_RESET    8'hC0
`define DRC_REFRESH_ON_BIT           7
`define DRC_REFRESH_WAIT_ADD_BIT     6
`define DRC_INTERVAL_SELECT_HI_BIT   1
`define DRC_INTERVAL_SELECT_LO_BIT   0

`define DRC_INTERVAL_SEL0            7'h0A
`define DRC_INTERVAL_SEL1            7'h14
`define DRC_INTERVAL_SEL2            7'h28
`define DRC_INTERVAL_SEL3            7'h50

`endif

//--- inc/drc_pkg.sv
// types shared by the refresh controller modules
package drc_pkg;

  typedef enum logic [1:0] {
    DRC_IDLE = 2'h0,
    DRC_T1   = 2'h1,
    DRC_T2   = 2'h3,
    DRC_TW   = 2'h2
  } drc_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } drc_sync_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } drc_timer_t;

  typedef struct packed {
    drc_state_t state;
    logic       pend;
    logic       held;
    logic       sleep_q;
    logic       refresh_on;
    logic       refresh_wait_add;
    logic [1:0] interval_select;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic       strobe;
    logic       refresh_wait_state;
  } drc_top_t;

endpackage

//--- core/drc_sync2.sv
// two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/10ps
module drc_sync2 (
  input  logic i_clk,
  input  logic i_arst_n,
  input  logic i_d,
  output logic o_q
);

  drc_pkg::drc_sync_t st;
  drc_pkg::drc_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '{s1: 1'h0, s2: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;

endmodule

//--- core/drc_interval_timer.sv
// refresh interval timer, one tick per programmed number of clock states
`timescale 1ns/10ps
`include "drc_regs.svh"
module drc_interval_timer (
  input  logic       i_clk,
  input  logic       i_rst_n,
  input  logic       i_run,
  input  logic [1:0] i_sel,
  output logic       o_tick
);

  drc_pkg::drc_timer_t st;
  drc_pkg::drc_timer_t next_st;

  function automatic logic [6:0] drc_reload(input logic [1:0] sel);
    case (sel)
      2'h0:    drc_reload = `DRC_INTERVAL_SEL0 - 7'h01;
      2'h1:    drc_reload = `DRC_INTERVAL_SEL1 - 7'h01;
      2'h2:    drc_reload = `DRC_INTERVAL_SEL2 - 7'h01;
      default: drc_reload = `DRC_INTERVAL_SEL3 - 7'h01;
    endcase
  endfunction

  // counts on regardless of bus ownership
  always_comb begin
    next_st      = st;
    next_st.tick = 1'h0;
    if (!i_run) begin
      next_st.cnt = drc_reload(i_sel);
    end else if (st.cnt == 7'h00) begin
      next_st.cnt  = drc_reload(i_sel);
      next_st.tick = 1'h1;
    end else begin
      next_st.cnt = st.cnt - 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{cnt: `DRC_INTERVAL_SEL0 - 7'h01, tick: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

endmodule

//--- core/drc_refresh_ctrl.sv
// dram refresh controller top: control register, request handling, refresh bus cycles
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "drc_regs.svh"
module drc_refresh_ctrl (
  input  logic       i_clk,
  input  logic       i_arst_n,
  input  logic [7:0] i_addr,
  input  logic [7:0] i_wdata,
  input  logic       i_wr,
  input  logic       i_rd,
  output logic [7:0] o_rdata,
  input  logic       i_bus_request_in,
  input  logic       i_sleep,
  input  logic       i_wait_state,
  input  logic       i_mcycle_end,
  output logic       o_refresh_strobe,
  output logic       o_refresh_wait_state,
  output logic [7:0] o_refresh_addr
);

  drc_pkg::drc_top_t st;
  drc_pkg::drc_top_t next_st;
  logic              rst_n;
  logic              bus_req;
  logic              tick;
  logic              start;

  function automatic logic drc_hit(input logic [7:0] addr);
    drc_hit = (addr == `DRC_REFRESH_CONTROL_OFS);
  endfunction

  // reset release
  drc_sync2 u_rst_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (1'h1),
    .o_q      (rst_n)
  );

  // bus request pin
  drc_sync2 u_bus_request_in_sync (
    .i_clk    (i_clk),
    .i_arst_n (rst_n),
    .i_d      (i_bus_request_in),
    .o_q      (bus_req)
  );

  drc_interval_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_run   (st.refresh_on),
    .i_sel   (st.interval_select),
    .o_tick  (tick)
  );

  always_comb begin
    start = (st.state == drc_pkg::DRC_IDLE) && st.pend && st.refresh_on
            && i_mcycle_end
            && !bus_req && !i_sleep && !i_wait_state;
  end

  always_comb begin
    next_st         = st;
    next_st.rdata   = 8'h00;
    next_st.sleep_q = i_sleep;

    // register access
    if (i_wr && drc_hit(i_addr)) begin
      next_st.refresh_on       = i_wdata[`DRC_REFRESH_ON_BIT];
      next_st.refresh_wait_add = i_wdata[`DRC_REFRESH_WAIT_ADD_BIT];
      next_st.interval_select  = {i_wdata[`DRC_INTERVAL_SELECT_HI_BIT],
                                  i_wdata[`DRC_INTERVAL_SELECT_LO_BIT]};
    end
    if (i_rd && drc_hit(i_addr)) begin
      next_st.rdata = {st.refresh_on, st.refresh_wait_add, 4'h0, st.interval_select};
    end

    // refresh bus cycle sequencer
    case (st.state)
      drc_pkg::DRC_IDLE: begin
        if (start) begin
          next_st.state  = drc_pkg::DRC_T1;
          next_st.strobe = 1'h1;
          next_st.pend   = 1'h0;
        end
      end
      drc_pkg::DRC_T1: begin
        next_st.state = drc_pkg::DRC_T2;
      end
      drc_pkg::DRC_T2: begin
        if (st.refresh_wait_add) begin
          next_st.state = drc_pkg::DRC_TW;
          next_st.refresh_wait_state   = 1'h1;
        end else begin
          next_st.state  = drc_pkg::DRC_IDLE;
          next_st.strobe = 1'h0;
          next_st.addr   = st.addr + 8'h01;
        end
      end
      drc_pkg::DRC_TW: begin
        next_st.state  = drc_pkg::DRC_IDLE;
        next_st.strobe = 1'h0;
        next_st.refresh_wait_state    = 1'h0;
        next_st.addr   = st.addr + 8'h01;
      end
      default: begin
        next_st.state  = drc_pkg::DRC_IDLE;
        next_st.strobe = 1'h0;
        next_st.refresh_wait_state    = 1'h0;
      end
    endcase

    // request bookkeeping; a new tick wins over the clear at start
    if (!st.refresh_on) begin
      next_st.pend = 1'h0;
      next_st.held = 1'h0;
    end else if (bus_req) begin
      next_st.pend = 1'h0;
      next_st.held = 1'h0;
    end else if (i_sleep) begin
      if (tick) begin
        next_st.held = 1'h1;
      end
    end else begin
      if (st.sleep_q && st.held) begin
        next_st.pend = 1'h1;
        next_st.held = 1'h0;
      end
      if (tick) begin
        next_st.pend = 1'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state:            drc_pkg::DRC_IDLE,
              pend:             1'h0,
              held:             1'h0,
              sleep_q:          1'h0,
              refresh_on:       1'h1,
              refresh_wait_add: 1'h1,
              interval_select:  2'h0,
              addr:             8'h00,
              rdata:            8'h00,
              strobe:           1'h0,
              refresh_wait_state:              1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata              = st.rdata;
  assign o_refresh_strobe     = st.strobe;
  assign o_refresh_wait_state = st.refresh_wait_state;
  assign o_refresh_addr       = st.addr;

endmodule

//--- verif/drc_props.sv
// port assertions of the refresh controller
`timescale 1ns/10ps
module drc_props (
  input logic       i_clk,
  input logic       i_arst_n,
  input logic [7:0] i_addr,
  input logic [7:0] i_wdata,
  input logic       i_wr,
  input logic       i_rd,
  input logic [7:0] o_rdata,
  input logic       i_bus_request_in,
  input logic       i_sleep,
  input logic       i_wait_state,
  input logic       i_mcycle_end,
  input logic       o_refresh_strobe,
  input logic       o_refresh_wait_state,
  input logic [7:0] o_refresh_addr
);
  logic [7:0] ctl;
  wire        s = o_refresh_strobe;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) ctl <= 8'hC0;
    else if (i_wr && i_addr == 8'h36) ctl <= i_wdata & 8'hC3;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_rd; i_rd && i_addr == 8'h36 |=> o_rdata == ctl; endproperty
  property p_len; $rose(s) |-> s[*2] ##1 ((!s) or (o_refresh_wait_state ##1 !s)); endproperty
  property p_tw; o_refresh_wait_state |-> s && $past(s, 2) && !$past(s, 3); endproperty
  property p_addr;
    $changed(o_refresh_addr) |-> $fell(s) && o_refresh_addr == $past(o_refresh_addr) + 8'h01;
  endproperty
  property p_gate; $rose(s) |-> $past(i_mcycle_end && !i_wait_state && !i_sleep); endproperty
  property p_bus; i_bus_request_in[*4] |-> !$rose(s); endproperty
  property p_on; $rose(s) |-> $past(ctl[7]); endproperty
  property p_stab; s |-> $stable(o_refresh_addr); endproperty
  a_rd: assert property (p_rd) else $error("bad control read");
  a_len: assert property (p_len) else $error("bad cycle length");
  a_tw: assert property (p_tw) else $error("bad wait clock");
  a_addr: assert property (p_addr) else $error("bad address step");
  a_gate: assert property (p_gate) else $error("bad cycle start");
  a_bus: assert property (p_bus) else $error("refresh while bus released");
  a_on: assert property (p_on) else $error("refresh while off");
  a_stab: assert property (p_stab) else $error("address moved in cycle");
  cover property ($rose(s));
  cover property (o_refresh_wait_state);
  cover property ($fell(i_sleep) ##[1:12] $rose(s));
endmodule

//--- verif/drc_dram_model.sv
// external dram model counting refresh cycles
`timescale 1ns/10ps
module drc_dram_model (
  input  logic       i_clk,
  input  logic       i_arst_n,
  input  logic       i_refresh_strobe,
  output logic [7:0] o_count
);
  logic prev;
  always @(posedge i_clk) begin
    prev <= i_refresh_strobe;
    if (!i_arst_n) o_count <= 8'h00;
    else if (i_refresh_strobe && !prev) o_count <= o_count + 8'h01;
  end
endmodule

//--- verif/tb.sv
// self-checking bench of the refresh controller
`timescale 1ns/10ps
module tb;
  logic       i_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_mcycle_end = 0;
  logic       i_bus_request_in = 0, i_sleep = 0, i_wait_state = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_refresh_addr, cnt, rv, a0;
  logic       o_refresh_strobe, o_refresh_wait_state;
  logic [2:0] mc = 0;
  int         n_fail = 0, tests_run = 0, gap, len, nw;
  logic [7:0] rows [4][4] = '{'{8'h80, 8'h80, 8'h0A, 8'h02}, '{8'hC1, 8'hC1, 8'h14, 8'h03},
                              '{8'h82, 8'h82, 8'h28, 8'h02}, '{8'hFF, 8'hC3, 8'h50, 8'h03}};
  drc_refresh_ctrl drc_refresh_ctrl_i (.*);
  drc_dram_model drc_dram_model_i (.i_clk, .i_arst_n, .i_refresh_strobe(o_refresh_strobe),
                                   .o_count(cnt));
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= 8'h36;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task rd(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(negedge i_clk);
    rv = o_rdata;
  endtask
  task meas();
    @(posedge o_refresh_strobe);
    len = 0;
    nw = 0;
    while (o_refresh_strobe !== 1'b0) begin
      @(posedge i_clk);
      #1 len++;
      if (o_refresh_wait_state === 1'b1) nw++;
    end
    gap = len;
    while (o_refresh_strobe !== 1'b1) begin
      @(posedge i_clk);
      #1 gap++;
    end
  endtask
  task final_report();
    $display("fails %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    mc <= (mc == 3'h4) ? 3'h0 : mc + 3'h1;
    i_mcycle_end <= (mc == 3'h4);
  end
  initial begin
    #100us;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1;
    repeat (3) @(posedge i_clk);
    rd(8'h36);
    chk("reset control", rv, 8'hC0);
    meas();
    chk("reset gap", 8'(gap), 8'h0A);
    chk("reset length", 8'(len), 8'h03);
    chk("reset wait clocks", 8'(nw), 8'h01);
    foreach (rows[k]) begin
      wr(8'h00);
      wr(rows[k][0]);
      rd(8'h36);
      chk("control", rv, rows[k][1]);
      meas();
      chk("gap", 8'(gap), rows[k][2]);
      chk("length", 8'(len), rows[k][3]);
      chk("wait clocks", 8'(nw), rows[k][3] - 8'h02);
      $display("row %0d done", k);
    end
    rd(8'h35);
    chk("unmapped read", rv, 8'h00);
    wr(8'h00);
    repeat (4) @(posedge i_clk);
    a0 = o_refresh_addr;
    repeat (200) @(posedge i_clk);
    chk("off address", o_refresh_addr, a0);
    wr(8'h80);
    i_bus_request_in <= 1;
    repeat (8) @(posedge i_clk);
    a0 = o_refresh_addr;
    repeat (100) @(posedge i_clk);
    chk("bus address", o_refresh_addr, a0);
    i_bus_request_in <= 0;
    meas();
    chk("bus gap", 8'(gap), 8'h0A);
    i_wait_state <= 1;
    repeat (8) @(posedge i_clk);
    a0 = o_refresh_addr;
    repeat (60) @(posedge i_clk);
    chk("wait address", o_refresh_addr, a0);
    i_wait_state <= 0;
    wr(8'h00);
    wr(8'h83);
    i_sleep <= 1;
    repeat (8) @(posedge i_clk);
    a0 = o_refresh_addr;
    repeat (100) @(posedge i_clk);
    chk("sleep address", o_refresh_addr, a0);
    i_sleep <= 0;
    len = 0;
    while (o_refresh_strobe !== 1'b1 && len < 20) begin
      @(posedge i_clk);
      #1 len++;
    end
    chk("replay soon", 8'(len < 12), 8'h01);
    repeat (10) @(posedge i_clk);
    do @(negedge i_clk); while (o_refresh_strobe !== 1'b0);
    chk("cycle count", cnt, o_refresh_addr);
    $display("sleep test done");
    @(posedge i_clk);
    i_arst_n <= 0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("mid reset strobe", {7'h00, o_refresh_strobe}, 8'h00);
    chk("mid reset address", o_refresh_addr, 8'h00);
    i_arst_n <= 1;
    repeat (3) @(posedge i_clk);
    rd(8'h36);
    chk("mid reset control", rv, 8'hC0);
    meas();
    chk("mid reset gap", 8'(gap), 8'h0A);
    chk("mid reset length", 8'(len), 8'h03);
    $display("mid reset test done");
    $display("scenarios done");
    final_report();
  end
endmodule
bind drc_refresh_ctrl drc_props drc_props_i (.*);
